// ### design/baud_gen.sv
// Baud generator with fractional prescaler, break filter and break sender
//
// Overview of operation
// R1: Filtered, 8-bit chars: break needs 11 bits
// R2: Filtered, 9-bit chars: break needs 12 bits
// R3: Zero data byte never reported as break
// R4: Software still checks measured break length itself
// R5: Register prescaler code selects 1, 3, 4, 13
// R6: Rate select divides by two to the code
// R7: Integer prescaler: 000 bypass, else code plus one
// R8: Software avoids bypass changes while enabled
// R9: Insert count extra clocks per 32-tick frame
// R10: Rate is bus over 64 times all divisors
// R11: All divisor and filter fields reset to zero
// R12: One generated clock feeds receiver and transmitter
// R13: Long break sends 13 or 14 bits
// R14: Bypass means divisor one, insertion ignored
`timescale 1ns/1ps
module baud_gen
   import baud_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Serial line
   input wire logic rx_pin,
   output logic tx_pin,
   // Shared timing to receiver and transmitter
   output logic rt_tick,
   output logic bit_tick
);

   // Register prescaler decode
   function automatic logic [3:0] reg_presc_div(input logic [1:0] sel);
      logic [3:0] r;
      r = REG_PRESC_DIV_0;
      unique case (sel)
         2'b00: r = REG_PRESC_DIV_0;
         2'b01: r = REG_PRESC_DIV_1;
         2'b10: r = REG_PRESC_DIV_2;
         2'b11: r = REG_PRESC_DIV_3;
      endcase
      return r;
   endfunction

   // Transmit break length in bit times
   function automatic logic [3:0] tx_break_len(input logic long_brk, input logic nine);
      logic [3:0] r;
      r = TX_BREAK_8;
      unique case ({long_brk, nine})
         2'b00: r = TX_BREAK_8;
         2'b01: r = TX_BREAK_9;
         2'b10: r = TX_BREAK_LONG_8;
         2'b11: r = TX_BREAK_LONG_9;
      endcase
      return r;
   endfunction

   // Register state
   baud_ctrl_s baud_q, baud_d;
   presc_ctrl_s presc_q, presc_d;
   logic enable_q, enable_d;
   logic nine_q, nine_d;
   logic break_seen_q, break_seen_d;
   logic [7:0] rdata_q, rdata_d;
   logic send_break;

   // Generator state
   logic [3:0] pc_q, pc_d;
   logic [4:0] frame_q, frame_d;
   logic [1:0] pre_q, pre_d;
   logic [3:0] bpdc_q, bpdc_d;
   logic [6:0] bdc_q, bdc_d;
   logic [3:0] rtc_q, rtc_d;
   logic rt_tick_q, rt_tick_d;
   logic bit_tick_q, bit_tick_d;
   logic presc_tick;
   logic [3:0] pc_last;
   logic [3:0] rpd_last;
   logic [6:0] rate_last;

   // Break sender state
   tx_state_e tx_q, tx_d;
   logic [3:0] txc_q, txc_d;
   logic tx_pin_q, tx_pin_d;

   // Filter results
   logic brk_pulse;
   logic [7:0] low_bits;
   logic rx_level;

   // ---------------- Registers ----------------
   assign send_break = wr && addr == ADDR_LINE_CTRL && wdata[LC_SEND_BREAK_BIT];

   always_comb begin
      baud_d = baud_q;
      presc_d = presc_q;
      enable_d = enable_q;
      nine_d = nine_q;
      break_seen_d = break_seen_q;
      rdata_d = 8'h00;
      if (wr) begin
         unique case (addr)
            ADDR_BAUD_CTRL: baud_d = baud_ctrl_s'(wdata & BAUD_CTRL_MASK);
            ADDR_PRESC_CTRL: presc_d = presc_ctrl_s'(wdata);
            ADDR_LINE_CTRL: begin
               enable_d = wdata[LC_ENABLE_BIT];
               nine_d = wdata[LC_NINE_BIT];
            end
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            ADDR_BAUD_CTRL: rdata_d = baud_q;
            ADDR_PRESC_CTRL: rdata_d = presc_q;
            ADDR_LINE_CTRL: begin
               rdata_d[LC_ENABLE_BIT] = enable_q;
               rdata_d[LC_NINE_BIT] = nine_q;
            end
            ADDR_LINE_STAT: begin
               rdata_d[LS_BREAK_SEEN_BIT] = break_seen_q;
               rdata_d[LS_TX_BREAK_BIT] = (tx_q != TX_IDLE);
               rdata_d[LS_RX_LEVEL_BIT] = rx_level;
               break_seen_d = 1'b0;
            end
            // R4: measured length left for software to judge
            ADDR_BREAK_LEN: rdata_d = low_bits;
            default: rdata_d = 8'h00;
         endcase
      end
      // A break landing on the clearing read is kept
      if (brk_pulse) begin
         break_seen_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      // R11: all fields start at zero
      if (srst) begin
         baud_q <= baud_ctrl_s'(BAUD_CTRL_RST);
         presc_q <= presc_ctrl_s'(PRESC_CTRL_RST);
         enable_q <= LINE_CTRL_RST[LC_ENABLE_BIT];
         nine_q <= LINE_CTRL_RST[LC_NINE_BIT];
         break_seen_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         baud_q <= baud_d;
         presc_q <= presc_d;
         enable_q <= enable_d;
         nine_q <= nine_d;
         break_seen_q <= break_seen_d;
         rdata_q <= rdata_d;
      end
   end

   // ---------------- Generator ----------------
   always_comb begin
      // R7: code n divides by n+1, last count is n
      // R9: first count-many ticks of each frame run one clock longer
      pc_last = {1'b0, presc_q.integer_prescaler_sel};
      if (presc_q.clock_insertion_count > frame_q) begin
         pc_last = pc_last + 4'h1;
      end
   end

   // R14: bypass passes every clock, insertion unused
   assign presc_tick = (presc_q.integer_prescaler_sel == 3'h0) || (pc_q == pc_last);
   // R5: register prescaler divisor
   assign rpd_last = reg_presc_div(baud_q.register_prescale_sel) - 4'h1;
   // R6: power-of-two rate divisor
   assign rate_last = 7'((8'h01 << baud_q.rate_select) - 8'h01);

   always_comb begin
      pc_d = pc_q;
      frame_d = frame_q;
      pre_d = pre_q;
      bpdc_d = bpdc_q;
      bdc_d = bdc_q;
      rtc_d = rtc_q;
      rt_tick_d = 1'b0;
      bit_tick_d = 1'b0;
      if (!enable_q) begin
         pc_d = 4'h0;
         frame_d = 5'h00;
         pre_d = 2'h0;
         bpdc_d = 4'h0;
         bdc_d = 7'h00;
         rtc_d = 4'h0;
      end else if (presc_tick) begin
         // R10: prescaler, 4, register prescaler, rate, 16 samples
         pc_d = 4'h0;
         frame_d = frame_q + 5'h01;
         pre_d = pre_q + 2'h1;
         if (pre_q == PRE_DIV_LAST) begin
            bpdc_d = (bpdc_q >= rpd_last) ? 4'h0 : bpdc_q + 4'h1;
            if (bpdc_q >= rpd_last) begin
               bdc_d = (bdc_q >= rate_last) ? 7'h00 : bdc_q + 7'h01;
               if (bdc_q >= rate_last) begin
                  rt_tick_d = 1'b1;
                  rtc_d = rtc_q + 4'h1;
                  bit_tick_d = (rtc_q == RT_PER_BIT_LAST);
               end
            end
         end
      end else begin
         pc_d = pc_q + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pc_q <= 4'h0;
         frame_q <= 5'h00;
         pre_q <= 2'h0;
         bpdc_q <= 4'h0;
         bdc_q <= 7'h00;
         rtc_q <= 4'h0;
         rt_tick_q <= 1'b0;
         bit_tick_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         frame_q <= frame_d;
         pre_q <= pre_d;
         bpdc_q <= bpdc_d;
         bdc_q <= bdc_d;
         rtc_q <= rtc_d;
         rt_tick_q <= rt_tick_d;
         bit_tick_q <= bit_tick_d;
      end
   end

   // ---------------- Break sender ----------------
   always_comb begin
      tx_d = tx_q;
      txc_d = txc_q;
      tx_pin_d = 1'b1;
      unique case (tx_q)
         TX_IDLE: begin
            if (send_break && enable_q) begin
               tx_d = TX_ARMED;
            end
         end
         // Waits for a bit boundary so every low bit is whole
         TX_ARMED: begin
            txc_d = 4'h0;
            if (bit_tick_q) begin
               tx_d = TX_BREAK;
               tx_pin_d = 1'b0;
            end
         end
         TX_BREAK: begin
            tx_pin_d = 1'b0;
            // R12: bit tick from the same generator whose rt_tick the receiver counts
            if (bit_tick_q) begin
               txc_d = txc_q + 4'h1;
               // R13: long break when master break transmit is set
               if (txc_q == tx_break_len(baud_q.master_break_transmit, nine_q) - 4'h1) begin
                  tx_d = TX_IDLE;
                  tx_pin_d = 1'b1;
               end
            end
         end
         default: tx_d = TX_IDLE;
      endcase
      if (!enable_q) begin
         tx_d = TX_IDLE;
         tx_pin_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         tx_q <= TX_IDLE;
         txc_q <= 4'h0;
         tx_pin_q <= 1'b1;
      end else begin
         tx_q <= tx_d;
         txc_q <= txc_d;
         tx_pin_q <= tx_pin_d;
      end
   end

   // R1: filter selects the longer receive threshold
   break_filter u_filter (
      .clk(clk),
      .srst(srst),
      .enable(enable_q),
      .filter_on(baud_q.slave_break_filter),
      .nine_bit(nine_q),
      .rt_tick(rt_tick_q),
      .rx_pin(rx_pin),
      .break_pulse(brk_pulse),
      .low_bits(low_bits),
      .rx_level(rx_level)
   );

   assign rdata = rdata_q;
   assign tx_pin = tx_pin_q;
   assign rt_tick = rt_tick_q;
   assign bit_tick = bit_tick_q;

endmodule

// ### design/break_filter.sv
// Receive break detector with optional long-break filter
`timescale 1ns/1ps
module break_filter
   import baud_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Settings
   input wire logic enable,
   input wire logic filter_on,
   input wire logic nine_bit,
   input wire logic rt_tick,
   // Line
   input wire logic rx_pin,
   // Results
   output logic break_pulse,
   output logic [7:0] low_bits,
   output logic rx_level
);

   logic s1_q, s2_q, s3_q;
   logic rx_q, rx_d;
   line_state_e st_q, st_d;
   logic [3:0] rt_q, rt_d;
   logic [7:0] bits_q, bits_d;
   logic [7:0] len_q, len_d;
   logic pulse_q, pulse_d;
   logic [7:0] thresh;

   always_comb begin
      // R1: 11 bits when filtered, 8-bit chars
      // R2: 12 bits when filtered, 9-bit chars
      unique case ({filter_on, nine_bit})
         2'b00: thresh = RX_BREAK_8;
         2'b01: thresh = RX_BREAK_9;
         2'b10: thresh = RX_BREAK_FILT_8;
         2'b11: thresh = RX_BREAK_FILT_9;
      endcase
   end

   always_comb begin
      // Pin level counts only once the two later stages agree
      rx_d = (s2_q == s3_q) ? s3_q : rx_q;
      st_d = st_q;
      rt_d = rt_q;
      bits_d = bits_q;
      len_d = len_q;
      pulse_d = 1'b0;
      if (!enable) begin
         st_d = LINE_HIGH;
         rt_d = 4'h0;
         bits_d = 8'h00;
      end else if (rx_q) begin
         if (st_q != LINE_HIGH) begin
            len_d = bits_q;
         end
         st_d = LINE_HIGH;
         rt_d = 4'h0;
         bits_d = 8'h00;
      end else begin
         if (st_q == LINE_HIGH) begin
            st_d = LINE_LOW;
         end
         if (rt_tick) begin
            rt_d = rt_q + 4'h1;
            if (rt_q == RT_PER_BIT_LAST && bits_q != 8'hFF) begin
               bits_d = bits_q + 8'h01;
            end
         end
         // R3: a zero data byte never reaches the threshold
         if (st_q == LINE_LOW && bits_q >= thresh) begin
            pulse_d = 1'b1;
            st_d = LINE_DONE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         rx_q <= 1'b1;
         st_q <= LINE_HIGH;
         rt_q <= 4'h0;
         bits_q <= 8'h00;
         len_q <= 8'h00;
         pulse_q <= 1'b0;
      end else begin
         s1_q <= rx_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         rx_q <= rx_d;
         st_q <= st_d;
         rt_q <= rt_d;
         bits_q <= bits_d;
         len_q <= len_d;
         pulse_q <= pulse_d;
      end
   end

   assign break_pulse = pulse_q;
   assign low_bits = len_q;
   assign rx_level = rx_q;

endmodule

// ### include/baud_pkg.sv
// Shared constants, field layouts and types for the baud generator block
package baud_pkg;

   // Register indices on the plain register port
   localparam int ADDR_W = 3;
   localparam logic [2:0] ADDR_BAUD_CTRL = 3'h0;
   localparam logic [2:0] ADDR_PRESC_CTRL = 3'h1;
   localparam logic [2:0] ADDR_LINE_CTRL = 3'h2;
   localparam logic [2:0] ADDR_LINE_STAT = 3'h3;
   localparam logic [2:0] ADDR_BREAK_LEN = 3'h4;

   // Reset values
   localparam logic [7:0] BAUD_CTRL_RST = 8'h00;
   localparam logic [7:0] PRESC_CTRL_RST = 8'h00;
   localparam logic [7:0] LINE_CTRL_RST = 8'h00;

   // Field positions in line_control
   localparam int LC_ENABLE_BIT = 0;
   localparam int LC_NINE_BIT = 1;
   localparam int LC_SEND_BREAK_BIT = 2;
   // Field positions in line_status
   localparam int LS_BREAK_SEEN_BIT = 0;
   localparam int LS_TX_BREAK_BIT = 1;
   localparam int LS_RX_LEVEL_BIT = 2;

   // Reserved bit of baud_rate_control reads as zero
   localparam logic [7:0] BAUD_CTRL_MASK = 8'hF7;

   // Fixed divide by 64 split as 4 before the sample tick and 16 samples a bit
   localparam logic [1:0] PRE_DIV_LAST = 2'h3;
   localparam logic [3:0] RT_PER_BIT_LAST = 4'hF;

   // Register prescaler divisors for codes 0..3
   localparam logic [3:0] REG_PRESC_DIV_0 = 4'h1;
   localparam logic [3:0] REG_PRESC_DIV_1 = 4'h3;
   localparam logic [3:0] REG_PRESC_DIV_2 = 4'h4;
   localparam logic [3:0] REG_PRESC_DIV_3 = 4'hD;

   // Break lengths in bit times
   localparam logic [7:0] RX_BREAK_8 = 8'h0A;
   localparam logic [7:0] RX_BREAK_9 = 8'h0B;
   localparam logic [7:0] RX_BREAK_FILT_8 = 8'h0B;
   localparam logic [7:0] RX_BREAK_FILT_9 = 8'h0C;
   localparam logic [3:0] TX_BREAK_8 = 4'hA;
   localparam logic [3:0] TX_BREAK_9 = 4'hB;
   localparam logic [3:0] TX_BREAK_LONG_8 = 4'hD;
   localparam logic [3:0] TX_BREAK_LONG_9 = 4'hE;

   typedef struct packed {
      logic master_break_transmit;
      logic slave_break_filter;
      logic [1:0] register_prescale_sel;
      logic reserved;
      logic [2:0] rate_select;
   } baud_ctrl_s;

   typedef struct packed {
      logic [2:0] integer_prescaler_sel;
      logic [4:0] clock_insertion_count;
   } presc_ctrl_s;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_ARMED = 2'b01,
      TX_BREAK = 2'b10
   } tx_state_e;

   typedef enum logic [1:0] {
      LINE_HIGH = 2'b00,
      LINE_LOW = 2'b01,
      LINE_DONE = 2'b10
   } line_state_e;

endpackage

// ### testbench/baud_gen_chk.sv
// Port checker for the baud generator, bound to its top module
`timescale 1ns/1ps
module baud_gen_chk
   import baud_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   // Line and timing
   input wire logic rx_pin,
   input wire logic tx_pin,
   input wire logic rt_tick,
   input wire logic bit_tick
);
   logic [7:0] sh0_q;
   logic [7:0] sh1_q;
   logic en_q;
   logic [3:0] rtc_q;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Shadow registers and sample count since the last bit tick
   always_ff @(posedge clk) begin
      if (srst) begin
         sh0_q <= 8'h00;
         sh1_q <= 8'h00;
         en_q <= 1'b0;
         rtc_q <= 4'h0;
      end else begin
         if (wr && addr == ADDR_BAUD_CTRL) sh0_q <= wdata & BAUD_CTRL_MASK;
         if (wr && addr == ADDR_PRESC_CTRL) sh1_q <= wdata;
         if (wr && addr == ADDR_LINE_CTRL) en_q <= wdata[LC_ENABLE_BIT];
         if (!en_q || bit_tick) rtc_q <= 4'h0;
         else if (rt_tick) rtc_q <= rtc_q + 4'h1;
      end
   end
   property p_reset_out;
      disable iff (1'b0) srst |=> !rt_tick && !bit_tick && tx_pin && rdata == 8'h00;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
   property p_rd_baud;
      rd && addr == ADDR_BAUD_CTRL |=> rdata == $past(sh0_q);
   endproperty
   a_rd_baud: assert property (p_rd_baud) else $error("baud control readback wrong");
   property p_rd_presc;
      rd && addr == ADDR_PRESC_CTRL |=> rdata == $past(sh1_q);
   endproperty
   a_rd_presc: assert property (p_rd_presc) else $error("prescaler readback wrong");
   property p_bit_on_rt;
      bit_tick |-> rt_tick;
   endproperty
   a_bit_on_rt: assert property (p_bit_on_rt) else $error("bit tick without sample tick");
   property p_rt_gap;
      rt_tick |=> !rt_tick [*3];
   endproperty
   a_rt_gap: assert property (p_rt_gap) else $error("sample ticks closer than 4");
   property p_bit_gap;
      bit_tick |=> !bit_tick [*8];
   endproperty
   a_bit_gap: assert property (p_bit_gap) else $error("bit ticks too close");
   property p_sixteen;
      bit_tick |-> rtc_q == 4'hF;
   endproperty
   a_sixteen: assert property (p_sixteen) else $error("bit tick not on 16th sample");
   property p_quiet_off;
      !en_q && !$past(en_q) |-> !rt_tick && !bit_tick;
   endproperty
   a_quiet_off: assert property (p_quiet_off) else $error("ticks while disabled");
   property p_tx_fall;
      $fell(tx_pin) |-> $past(bit_tick) || $past(bit_tick, 2);
   endproperty
   a_tx_fall: assert property (p_tx_fall) else $error("break start off bit boundary");
   c_tx_break: cover property (bit_tick && !tx_pin);
   c_rd_baud: cover property (rd && addr == ADDR_BAUD_CTRL);
   c_rx_low: cover property ($fell(rx_pin));
endmodule

bind baud_gen baud_gen_chk u_baud_gen_chk (.clk(clk), .srst(srst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
   .rt_tick(rt_tick), .bit_tick(bit_tick));

// ### testbench/line_node.sv
// Remote node on the serial line, idle recessive
`timescale 1ns/1ps
module line_node (
   // Clock
   input wire logic clk,
   // Line
   output logic rx_pin
);
   initial rx_pin = 1'b1;
   // dominant spans like a break or a zero byte
   task automatic hold_low(input int n);
      @(posedge clk);
      rx_pin <= 1'b0;
      repeat (n) @(posedge clk);
      rx_pin <= 1'b1;
   endtask
endmodule

// ### testbench/serial_baud_generator_break_filter_bench.sv
// Self-checking bench for the baud generator and break logic
`timescale 1ns/1ps
module serial_baud_generator_break_filter_bench
   import baud_pkg::*;
;
   logic clk, srst, wr, rd, rx_pin, tx_pin, rt_tick, bit_tick;
   logic [ADDR_W-1:0] addr;
   logic [7:0] wdata, rdata, v;
   logic [15:0] w;
   logic [31:0] seed;
   int n_mismatch, num_checks, p;
   int cyc = 0;
   logic [15:0] cases [11] = '{16'h0000, 16'h1000, 16'h2000, 16'h3000, 16'h0300, 16'h0700,
      16'h0020, 16'h00FF, 16'h001F, 16'h00E1, 16'h2121};
   int rx_len [5] = '{662, 736, 736, 800, 662};
   logic [7:0] rx_cfg [5] = '{8'h40, 8'h40, 8'h42, 8'h42, 8'h00};
   logic rx_exp [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   logic [7:0] tx_b [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
   logic [7:0] tx_c [4] = '{8'h05, 8'h05, 8'h07, 8'h07};
   int tx_bits [4] = '{10, 13, 14, 11};
   baud_gen u_baud_gen (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .rt_tick(rt_tick), .bit_tick(bit_tick));
   line_node u_line_node (.clk(clk), .rx_pin(rx_pin));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Exact over one bit: a bit spans a whole number of 32-tick frames
   function automatic int exp_per(input logic [7:0] b, input logic [7:0] q);
      int k;
      k = 64 * (b[5:4] == 2'h0 ? 1 : b[5:4] == 2'h1 ? 3 : b[5:4] == 2'h2 ? 4 : 13);
      k = k * (1 << b[2:0]);
      if (q[7:5] == 3'h0) return k;
      return k * (q[7:5] + 1) + k / 32 * q[4:0];
   endfunction
   task automatic end_of_test();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Settings change only while disabled: bypass switching glitches
   task automatic set_gen(input logic [7:0] b, input logic [7:0] q, input logic [7:0] c);
      wr_reg(ADDR_LINE_CTRL, 8'h00);
      wr_reg(ADDR_BAUD_CTRL, b);
      wr_reg(ADDR_PRESC_CTRL, q);
      wr_reg(ADDR_LINE_CTRL, c);
   endtask
   task automatic meas(output int n);
      n = 0;
      do @(posedge clk); while (bit_tick !== 1'b1 && ++n < 20000);
      n = 0;
      do @(posedge clk); while (bit_tick !== 1'b1 && ++n < 20000);
      n++;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      srst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      seed = 32'he8bd;
      n_mismatch = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      // Status shows the idle-high line level after reset
      for (int a = 0; a < 6; a++) begin
         rd_reg(a[2:0], v);
         chk8(v, (a == 3) ? 8'h04 : 8'h00);
      end
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr_reg(ADDR_BAUD_CTRL, seed[7:0]);
         wr_reg(ADDR_PRESC_CTRL, seed[15:8]);
         wr_reg(3'h5, seed[23:16]);
         rd_reg(ADDR_BAUD_CTRL, v);
         chk8(v, seed[7:0] & 8'hF7);
         rd_reg(ADDR_PRESC_CTRL, v);
         chk8(v, seed[15:8]);
         rd_reg(3'h5, v);
         chk8(v, 8'h00);
      end
      for (int i = 0; i < 15; i++) begin
         seed = lfsr(seed);
         w = (i < 11) ? cases[i] : (seed[15:0] & 16'h11FF);
         set_gen(w[15:8], w[7:0], 8'h01);
         meas(p);
         chk_n(p, exp_per(w[15:8], w[7:0]));
      end
      for (int i = 0; i < 5; i++) begin
         set_gen(rx_cfg[i] & 8'h40, 8'h00, 8'h01 | (rx_cfg[i] & 8'h02));
         rd_reg(ADDR_LINE_STAT, v);
         u_line_node.hold_low(rx_len[i]);
         repeat (200) @(posedge clk);
         rd_reg(ADDR_LINE_STAT, v);
         chk8({7'h00, v[0]}, {7'h00, rx_exp[i]});
         rd_reg(ADDR_BREAK_LEN, v);
         chk8(v, 8'(rx_len[i] / 64));
      end
      for (int i = 0; i < 4; i++) begin
         // Break request only counts once the enable already stands
         set_gen(tx_b[i], 8'h00, tx_c[i] & 8'h03);
         wr_reg(ADDR_LINE_CTRL, tx_c[i]);
         p = 0;
         while (tx_pin === 1'b1 && p < 5000) begin
            @(posedge clk);
            p++;
         end
         p = 0;
         while (tx_pin === 1'b0 && p < 5000) begin
            @(posedge clk);
            p++;
         end
         chk_n(p, 64 * tx_bits[i]);
      end
      end_of_test();
   end
endmodule
